// ===== hw/swl_consts.svh
// Timing constants of the single-wire time-slot link, device end
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define SWL_CLK_MHZ        20
`define SWL_CNT_W          16

// ****************************************************************
// Times in microseconds
// ****************************************************************
`define SWL_T_WIN_LO_US    15
`define SWL_T_WIN_HI_US    60
`define SWL_T_SAMPLE_US    30
`define SWL_T_READ_HOLD_US 30
`define SWL_T_RST_DET_US   440
`define SWL_T_PDH_US       30
`define SWL_T_PDL_US       120

// ****************************************************************
// Cycle counts derived from the times (exact at whole MHz)
// ****************************************************************
`define SWL_WIN_LO_CYC     (`SWL_T_WIN_LO_US * `SWL_CLK_MHZ)
`define SWL_WIN_HI_CYC     (`SWL_T_WIN_HI_US * `SWL_CLK_MHZ)
`define SWL_SAMPLE_CYC     (`SWL_T_SAMPLE_US * `SWL_CLK_MHZ)
`define SWL_READ_HOLD_CYC  (`SWL_T_READ_HOLD_US * `SWL_CLK_MHZ)
`define SWL_RST_DET_CYC    (`SWL_T_RST_DET_US * `SWL_CLK_MHZ)
`define SWL_PDH_CYC        (`SWL_T_PDH_US * `SWL_CLK_MHZ)
`define SWL_PDL_CYC        (`SWL_T_PDL_US * `SWL_CLK_MHZ)

`endif

// ===== hw/swl_pkg.sv
// Types shared by the single-wire link device end
package swl_pkg;

  typedef enum logic [2:0] {
    SWL_IDLE       = 3'b000,
    SWL_SLOT       = 3'b001,
    SWL_RST_LOW    = 3'b010,
    SWL_PRES_WAIT  = 3'b011,
    SWL_PRES_DRIVE = 3'b100
  } swl_state_t;

  typedef struct packed {
    logic slot_is_read;
    logic tx_bit;
  } swl_user_in_t;

  typedef struct packed {
    logic rx_valid;
    logic rx_bit;
    logic reset_seen;
    logic presence_done;
  } swl_user_out_t;

  typedef struct packed {
    swl_state_t    state;
    logic [15:0]   cnt;
    logic          prev;
    logic          rd;
    logic          oe;
    logic          dq_lvl;
    swl_user_out_t out;
  } swl_core_t;

  typedef struct packed {
    logic [15:0] cnt;
  } swl_tmr_t;

endpackage : swl_pkg

// ===== hw/swl_low_timer.sv
// Saturating counter of how long the data line has stayed low
`timescale 1ns/10ps
`default_nettype none

module swl_low_timer #(
  parameter int unsigned SAT = 16'hFFFF
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clr,
  output logic [15:0]      count_q
);
  import swl_pkg::*;

  swl_tmr_t q;
  swl_tmr_t d;

  always_comb begin
    d = q;
    if (clr) begin
      d.cnt = 16'h0000;
    end else if (q.cnt != 16'(SAT)) begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count_q = q.cnt;

endmodule : swl_low_timer

`default_nettype wire

// ===== hw/swl_link.sv
// Device end of the single-wire time-slot link: slots, reset and presence
`timescale 1ns/10ps
`default_nettype none
`include "swl_consts.svh"

module swl_link #(
  parameter int unsigned RST_DET_CYC = `SWL_RST_DET_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  dq_i,
  output logic                       dq_o,
  output logic                       dq_oe,
  input  wire swl_pkg::swl_user_in_t user_in,
  output swl_pkg::swl_user_out_t     user_out
);
  import swl_pkg::*;

  // ****************************************************************
  // Timing thresholds
  // ****************************************************************
  localparam logic [15:0] SAMPLE_C = 16'(`SWL_SAMPLE_CYC);
  localparam logic [15:0] HOLD_C   = 16'(`SWL_READ_HOLD_CYC);
  localparam logic [15:0] PDH_C    = 16'(`SWL_PDH_CYC);
  localparam logic [15:0] PDL_C    = 16'(`SWL_PDL_CYC);
  localparam logic [15:0] RST_C    = 16'(RST_DET_CYC);
  localparam logic [15:0] WIN_LO_C = 16'(`SWL_WIN_LO_CYC);
  localparam logic [15:0] WIN_HI_C = 16'(`SWL_WIN_HI_CYC);

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  swl_core_t   q;
  swl_core_t   d;
  logic [15:0] low_cnt;
  logic        fall;
  logic        reset_det;

  // ****************************************************************
  // Low-time measurement
  // ****************************************************************
  swl_low_timer #(
    .SAT (16'hFFFF)
  ) u_low_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clr      (dq_i),
    .count_q  (low_cnt)
  );

  assign fall      = q.prev & ~dq_i;
  // Line high this cycle means the low has ended, even if the timer lags
  assign reset_det = ~dq_i & (low_cnt >= RST_C);

  // ****************************************************************
  // Slot and presence engine
  // ****************************************************************
  always_comb begin
    d                   = q;
    d.prev              = dq_i;
    d.dq_lvl            = 1'b0;
    d.out.rx_valid      = 1'b0;
    d.out.reset_seen    = 1'b0;
    d.out.presence_done = 1'b0;
    if (reset_det && q.state != SWL_RST_LOW) begin
      // Abort whatever was running and let go of the line
      d.state = SWL_RST_LOW;
      d.oe    = 1'b0;
      d.cnt   = 16'h0000;
    end else begin
      case (q.state)
        SWL_IDLE: begin
          if (fall) begin
            d.state = SWL_SLOT;
            d.cnt   = 16'h0000;
            d.rd    = user_in.slot_is_read;
            // Drive at once: the host already holds the line low
            d.oe    = user_in.slot_is_read & ~user_in.tx_bit;
          end
        end
        SWL_SLOT: begin
          d.cnt = sat_inc(q.cnt);
          if (!q.rd && q.cnt == SAMPLE_C) begin
            d.out.rx_valid = 1'b1;
            d.out.rx_bit   = dq_i;
          end
          if (q.rd && q.cnt == HOLD_C) begin
            d.oe = 1'b0;
          end
          // Besides a reset-length low, only a high line after the sample point ends the slot
          if (q.cnt > SAMPLE_C && dq_i && !q.oe) begin
            d.state = SWL_IDLE;
          end
        end
        SWL_RST_LOW: begin
          d.oe = 1'b0;
          if (dq_i) begin
            d.state          = SWL_PRES_WAIT;
            d.cnt            = 16'h0000;
            d.out.reset_seen = 1'b1;
          end
        end
        SWL_PRES_WAIT: begin
          d.cnt = sat_inc(q.cnt);
          if (q.cnt == PDH_C - 16'h0001) begin
            d.state = SWL_PRES_DRIVE;
            d.cnt   = 16'h0000;
            d.oe    = 1'b1;
          end
        end
        SWL_PRES_DRIVE: begin
          d.cnt = sat_inc(q.cnt);
          if (q.cnt == PDL_C - 16'h0001) begin
            d.state             = SWL_IDLE;
            d.oe                = 1'b0;
            d.out.presence_done = 1'b1;
          end
        end
        default: begin
          d.state = SWL_IDLE;
          d.oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.prev  <= 1'b1;
      q.state <= SWL_IDLE;
    end else begin
      q <= d;
    end
  end

  assign dq_o     = q.dq_lvl;
  assign dq_oe    = q.oe;
  assign user_out = q.out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int RD_LO  = 1;
  localparam int RD_HI  = 2;

  logic [15:0] pres_len_q;
  logic [15:0] gap_len_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pres_len_q <= 16'h0000;
    end else if (q.state == SWL_PRES_DRIVE) begin
      pres_len_q <= sat_inc(pres_len_q);
    end else begin
      pres_len_q <= 16'h0000;
    end
  end

  // The quiet gap is far too long for a delay range, so it is counted here
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_len_q <= 16'h0000;
    end else if (q.state == SWL_PRES_WAIT) begin
      gap_len_q <= sat_inc(gap_len_q);
    end else begin
      gap_len_q <= 16'h0000;
    end
  end

  sequence s_idle_fall;
    q.state == SWL_IDLE && q.prev && !dq_i && !reset_det;
  endsequence

  sequence s_reset_rise;
    q.state == SWL_RST_LOW && dq_i;
  endsequence

  a_fall_starts_slot: assert property (@(posedge core_clk) disable iff (rst)
    s_idle_fall |=> q.state == SWL_SLOT && q.cnt == 16'h0000)
    else $error("falling edge in idle did not open a slot");

  a_sample_window: assert property (@(posedge core_clk) disable iff (rst)
    user_out.rx_valid |-> q.state == SWL_SLOT && !q.rd && q.cnt > WIN_LO_C && q.cnt <= WIN_HI_C)
    else $error("write bit taken outside the sampling window");

  a_sample_value: assert property (@(posedge core_clk) disable iff (rst)
    user_out.rx_valid |-> user_out.rx_bit == $past(dq_i))
    else $error("write bit does not match the sampled line");

  a_read_drive_early: assert property (@(posedge core_clk) disable iff (rst)
    s_idle_fall ##0 (user_in.slot_is_read && !user_in.tx_bit) |-> ##[RD_LO:RD_HI] dq_oe)
    else $error("read zero not driven promptly");

  a_read_release: assert property (@(posedge core_clk) disable iff (rst)
    (q.state == SWL_SLOT && q.rd && q.cnt > HOLD_C) |-> !dq_oe)
    else $error("read slot drive held past the release point");

  a_presence_gap: assert property (@(posedge core_clk) disable iff (rst)
    $rose(q.state == SWL_PRES_DRIVE) |-> dq_oe && gap_len_q >= 16'h012B && gap_len_q <= 16'h04AF)
    else $error("presence pulse did not start within the gap");

  a_reset_rise: assert property (@(posedge core_clk) disable iff (rst)
    s_reset_rise |=> q.state == SWL_PRES_WAIT && !dq_oe && user_out.reset_seen)
    else $error("end of reset low did not start the presence wait");

  a_presence_quiet: assert property (@(posedge core_clk) disable iff (rst)
    q.state == SWL_PRES_WAIT |-> !dq_oe)
    else $error("line driven during the presence wait");

  a_presence_len: assert property (@(posedge core_clk) disable iff (rst)
    $fell(q.state == SWL_PRES_DRIVE) && !$past(reset_det) |->
      $past(pres_len_q) >= 16'd1199 && $past(pres_len_q) <= 16'd4799 && !dq_oe && user_out.presence_done)
    else $error("presence pulse length out of range");

  a_reset_abort: assert property (@(posedge core_clk) disable iff (rst)
    (reset_det && q.state != SWL_RST_LOW) |=> q.state == SWL_RST_LOW && !dq_oe)
    else $error("reset-length low did not abort the engine");

endmodule : swl_link

`default_nettype wire

// ===== testbench/swl_host_model.sv
// Host bus master model driving the single-wire link through an open-drain low
`timescale 1ns/10ps
`default_nettype none

module swl_host_model (
  input  wire logic core_clk,
  input  wire logic dq,
  output var logic  host_low
);
  initial host_low = 1'b0;

  // ****************************************************************
  // Slot primitives, each one timed from its own falling edge
  // ****************************************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  task automatic write_slot(input logic b);
    int lt;
    lt = b ? 20 : 1200;
    @(posedge core_clk);
    #1;
    host_low = 1'b1;
    wait_cyc(lt);
    host_low = 1'b0;
    wait_cyc(1300 - lt);
    wait_cyc(40);
  endtask : write_slot

  task automatic read_slot(output logic v, output logic end_lvl);
    @(posedge core_clk);
    #1;
    host_low = 1'b1;
    wait_cyc(20);
    host_low = 1'b0;
    wait_cyc(280);
    v = dq;
    wait_cyc(999);
    end_lvl = dq;
    wait_cyc(41);
  endtask : read_slot

  // Low time is the caller's so a long low can cut into a slot
  task automatic reset_pulse(input int low_cyc);
    @(posedge core_clk);
    #1;
    host_low = 1'b1;
    wait_cyc(low_cyc);
    host_low = 1'b0;
  endtask : reset_pulse
endmodule : swl_host_model

`default_nettype wire

// ===== testbench/tb_single_wire_time_slot_link.sv
// Self-checking bench of the single-wire link device end
`timescale 1ns/10ps
`default_nettype none
`include "swl_consts.svh"

module tb_single_wire_time_slot_link;
  import swl_pkg::*;

  // Host reset low kept just over the 480 us minimum, above the detect threshold
  localparam int unsigned RST_LOW = 485 * `SWL_CLK_MHZ;

  logic          core_clk;
  logic          rst;
  logic          host_low;
  logic          dq_o;
  logic          dq_oe;
  wire logic     dq_line;
  swl_user_in_t  user_in;
  swl_user_out_t user_out;
  int            num_errors;
  int            n_compared;
  int            cycles;

  // Wired-AND of both pull-downs with the pull-up
  assign dq_line = !(host_low || (dq_oe && !dq_o));

  swl_link #(.RST_DET_CYC(`SWL_RST_DET_CYC)) u_swl_link (
    .core_clk(core_clk), .rst(rst), .dq_i(dq_line), .dq_o(dq_o),
    .dq_oe(dq_oe), .user_in(user_in), .user_out(user_out)
  );

  swl_host_model u_swl_host_model (.core_clk(core_clk), .dq(dq_line), .host_low(host_low));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Optionally start from a read-zero slot so the long low aborts it
  task automatic test_reset(input logic from_slot);
    int n;
    int m;
    user_in = '{slot_is_read: from_slot, tx_bit: 1'b0};
    u_swl_host_model.reset_pulse(RST_LOW);
    @(posedge core_clk);
    #1;
    chk("reset_seen", user_out.reset_seen, 1);
    n = 1;
    while (dq_oe !== 1'b1 && n < 1300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("presence gap ok", (n >= 300 && n <= 1200), 1);
    m = 0;
    while (dq_oe === 1'b1 && m < 5000) begin
      chk("line low in presence", dq_line, 0);
      @(posedge core_clk);
      #1;
      m++;
    end
    chk("presence low ok", (m >= 1200 && m <= 4800), 1);
    chk("presence_done", user_out.presence_done, 1);
    u_swl_host_model.wait_cyc(40);
    $display("test reset from_slot=%0d done", from_slot);
  endtask : test_reset

  task automatic test_write;
    logic [3:0] pat;
    int         n;
    pat = 4'hA;
    user_in = '{slot_is_read: 1'b0, tx_bit: 1'b0};
    for (int i = 0; i < 4; i++) begin
      fork
        u_swl_host_model.write_slot(pat[i]);
        begin
          n = 0;
          @(posedge core_clk);
          #1;
          while (user_out.rx_valid !== 1'b1 && n < 1250) begin
            @(posedge core_clk);
            #1;
            n++;
          end
          chk("rx_valid in window", (n >= 300 && n <= 1200), 1);
          chk("rx_bit", user_out.rx_bit, pat[i]);
          chk("no drive in write", dq_oe, 0);
        end
      join
    end
    $display("test write done");
  endtask : test_write

  task automatic test_read;
    logic v;
    logic e;
    for (int i = 0; i < 4; i++) begin
      user_in = '{slot_is_read: 1'b1, tx_bit: i[0]};
      u_swl_host_model.read_slot(v, e);
      chk("read bit", v, i[0]);
      chk("line high at slot end", e, 1);
    end
    user_in = '{slot_is_read: 1'b0, tx_bit: 1'b0};
    $display("test read done");
  endtask : test_read

  // ****************************************************************
  // Clock, reset, timeout and main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    rst = 1'b1;
    user_in = '{slot_is_read: 1'b0, tx_bit: 1'b0};
    repeat (12) @(posedge core_clk);
    #1;
    chk("dq_oe in reset", dq_oe, 0);
    rst = 1'b0;
    u_swl_host_model.wait_cyc(4);
    test_reset(1'b0);
    test_write();
    test_read();
    test_reset(1'b1);
    test_write();
    tally_and_finish();
  end
endmodule : tb_single_wire_time_slot_link

`default_nettype wire
